// ---- i2cf_core.sv ----
// Two-wire bus framing core: framing, start/stop, stretching, arbitration
// What this block does
// - Each unit is eight data bits then one acknowledge bit.
// - Sender releases data after the eighth falling clock, samples acknowledge next.
// - Data changes only with clock low; receivers sample on clock rise.
// - Data falling while clock high is a start; bus becomes active.
// - Data rising while clock high is a stop.
// - A stop counts only after one clock low period since start.
// - With port enabled in bus mode, both pins act open drain.
// - Hold select stretches data hold after clock fall to 300 ns.
// - Release bit clear: wait for clock low, then hold it low.
// - Host tracks start and stop and waits for an idle bus.
// - Transmitter compares sampled data; first mismatch loses and releases data.
// - Losing host also releases clock and waits for a stop to retry.
// - Data sampled low while driving high flags a bus collision.
// - Data seen low before driving the start low flags a collision.
// - Bus idle only with no start awaiting its stop and both lines high.
// - Start and stop enables raise the port event in modes lacking it.
// - After a read address the client supplies bytes until a not-acknowledge, restart or stop.
// - Address equal to own address matches; clear direction bit means write.
// - Client transmission is also arbitrated on the data line.
// - Bytes move most significant bit first.
// - Direction bit one means read, zero means write.
// - A complete received byte goes to the buffer and raises the event.
`timescale 1ns/1ps
module i2cf_core
    import i2cf_pkg::*;
#(
    parameter int HALF_CYCLES = HALF_CYC
) (
    input  wire logic       ref_clk,           // System clock
    input  wire logic       rst_n,             // Synchronous reset, active low
    input  wire logic       scl_in,            // Clock line level, also the link clock
    output logic            scl_out,           // Clock line drive value, always low
    output logic            scl_oe,            // Clock line pulled low when high
    input  wire logic       sda_in,            // Data line level
    output logic            sda_out,           // Data line drive value, always low
    output logic            sda_oe,            // Data line pulled low when high
    input  wire logic       port_enable_bit,   // Port enable
    input  wire logic       i2c_mode_sel,      // A bus mode is selected
    input  wire logic       clock_release_bit, // Clear to stretch the clock
    input  wire logic       sda_hold_select,   // Long data hold
    input  wire logic       start_irq_enable,  // Event on start
    input  wire logic       stop_irq_enable,   // Event on stop
    input  wire logic       ss_irq_mode,       // Mode that already flags start/stop
    input  wire logic [7:0] own_address_reg,   // Own address in bits 7:1
    input  wire logic       host_go,           // Pulse: send one byte as host
    input  wire logic [7:0] tx_data,           // Byte to transmit
    input  wire logic       flag_clear,        // Pulse: clear sticky flags
    output logic [7:0]      rx_data,           // Last received byte
    output logic            port_event_flag,   // Pulse: byte, start or stop event
    output logic            tx_take,           // Pulse: tx_data was loaded
    output logic            host_done,         // Pulse: host transfer ended
    output logic            ack_status,        // Last acknowledge was low
    output logic            addressed,         // Client matched own address
    output logic            bus_busy,          // Bus active
    output logic            bus_idle,          // Bus idle
    output logic            arb_lost,          // Sticky lost arbitration
    output logic            bus_coll           // Sticky bus collision
);

    i2cf_state_t q, d;
    i2cf_link_t  lk_q, lk_d;

    logic       en_w, rise_w, fall_w, start_w, stop_w;
    logic       txon_w, want_w, lose_w, scoll_w, hact_w;
    logic [7:0] nb_w;

    // Link domain: sample data on each clock rise and flip a toggle for the system side
    // capture on rise
    always_comb
    begin
        lk_d      = lk_q;
        lk_d.r1   = rst_n;
        lk_d.r2   = lk_q.r1;
        if (!lk_q.r2)
        begin
            lk_d.bitv = 1'b0;
            lk_d.tog  = 1'b0;
        end
        else
        begin
            lk_d.bitv = sda_in;
            lk_d.tog  = ~lk_q.tog;
        end
    end

    always_ff @(posedge scl_in)
    begin
        lk_q <= lk_d;
    end

    // Bus events; the sampled bit is stable for a whole bus period after the toggle lands
    assign en_w    = port_enable_bit & i2c_mode_sel;
    assign rise_w  = q.tg_s ^ q.tg_p;
    assign fall_w  = q.scl_p & ~q.scl_s;
    assign start_w = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    // stop detect after a clock low
    assign stop_w  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s & q.lowseen;
    assign txon_w  = q.htx | q.cltx;
    assign want_w  = q.txs[3'(BIT_LAST - q.cnt)];
    assign nb_w    = {q.sh[6:0], lk_q.bitv};
    assign lose_w  = rise_w & (q.cnt < BIT_ACK) & txon_w & want_w & ~lk_q.bitv;
    assign scoll_w = (q.hst == H_START) & ~q.sda_s;
    assign hact_w  = (q.hst == H_START) | (q.hst == H_SDALOW) | (q.hst == H_LOW)
                   | (q.hst == H_HIGH) | (q.hst == H_STOP);

    // Next-state logic for the system side
    always_comb
    begin
        d      = q;
        d.scl_m = scl_in;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = sda_in;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.tg_m  = lk_q.tog;
        d.tg_s  = q.tg_m;
        d.tg_p  = q.tg_s;
        d.evt   = 1'b0;
        d.take  = 1'b0;
        d.done  = 1'b0;
        if (!q.scl_s)
            d.lowseen = 1'b1;
        d.age = (&q.age) ? q.age : q.age + 1'b1;

        // apply pending data level only after the hold count
        if (q.hold != '0)
        begin
            d.hold = q.hold - 1'b1;
            if (q.hold == HOLD_W'(1))
                d.sdal = q.pend;
        end

        // bit slots counted on rises, ack slot last
        if (rise_w)
        begin
            if (q.cnt < BIT_ACK)
            begin
                d.sh  = nb_w;
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == BIT_LAST)
                begin
                    d.rxb = nb_w;
                    d.evt = 1'b1;
                    if (q.first)
                    begin
                        d.addr = (nb_w[7:1] == own_address_reg[7:1]);
                        d.rw   = nb_w[0];
                    end
                end
            end
            else if (q.cnt == BIT_ACK)
            begin
                d.ack = ~lk_q.bitv;
                d.cnt = BIT_DONE;
                if (lk_q.bitv)
                    d.cltx = 1'b0;
            end
        end

        // next level chosen on clock fall, driven after hold
        if (fall_w)
        begin
            d.hold = sda_hold_select ? HOLD_W'(HOLD_LONG_CYC) : HOLD_W'(HOLD_SHORT_CYC);
            d.age  = '0;
            d.pend = 1'b0;
            if (q.cnt == BIT_DONE)
            begin
                d.cnt   = '0;
                d.first = 1'b0;
                d.htx   = 1'b0;
                // keep supplying bytes while the host acknowledges
                if (q.addr & q.rw & (q.first | q.cltx))
                begin
                    d.cltx = 1'b1;
                    d.txs  = tx_data;
                    d.take = 1'b1;
                    d.pend = ~tx_data[7];
                end
            end
            else if (q.cnt < BIT_ACK)
                d.pend = txon_w & ~want_w;
            else
                d.pend = q.addr & ~txon_w & (q.first | ~q.rw);
        end

        if (start_w)
        begin
            d.busy    = 1'b1;
            d.cnt     = '0;
            d.first   = 1'b1;
            d.cltx    = 1'b0;
            d.addr    = 1'b0;
            d.lowseen = 1'b0;
            d.hold    = '0;
            d.sdal    = 1'b0;
            if (start_irq_enable | ss_irq_mode)
                d.evt = 1'b1;
        end
        if (stop_w)
        begin
            d.busy = 1'b0;
            d.addr = 1'b0;
            d.cltx = 1'b0;
            d.htx  = 1'b0;
            if (stop_irq_enable | ss_irq_mode)
                d.evt = 1'b1;
        end

        // grab the clock only once it is already low
        d.sclh = ~clock_release_bit & (q.sclh | ~q.scl_s);

        // Host sequencer; half period restarts while another party stretches
        if (q.tmr != '0)
            d.tmr = q.tmr - 1'b1;
        case (q.hst)
            H_IDLE:
                if (host_go)
                    d.hst = H_WAIT;
            H_WAIT:
                // begin only on an idle bus
                if (!q.busy && q.scl_s && q.sda_s)
                begin
                    d.hst = H_START;
                    d.tmr = TMR_W'(HALF_CYCLES);
                end
            H_START:
                if (q.tmr == '0)
                begin
                    d.hsda = 1'b1;
                    d.hst  = H_SDALOW;
                    d.tmr  = TMR_W'(HALF_CYCLES);
                end
            H_SDALOW:
                if (q.tmr == '0)
                begin
                    d.hscl = 1'b1;
                    d.hsda = 1'b0;
                    d.sdal = 1'b1;
                    d.htx  = 1'b1;
                    d.txs  = tx_data;
                    d.take = 1'b1;
                    d.tmr  = TMR_W'(HALF_CYCLES);
                    d.hst  = H_LOW;
                end
            H_LOW:
                if (q.tmr == '0)
                begin
                    d.hscl = 1'b0;
                    d.tmr  = TMR_W'(HALF_CYCLES);
                    d.hst  = H_HIGH;
                end
            H_HIGH:
                if (!q.scl_s)
                    d.tmr = TMR_W'(HALF_CYCLES);
                else if (q.tmr == '0)
                begin
                    d.hscl = 1'b1;
                    d.tmr  = TMR_W'(HALF_CYCLES);
                    d.hst  = (q.cnt == BIT_DONE) ? H_STOP : H_LOW;
                end
            H_STOP:
                if (q.tmr == '0)
                begin
                    d.tmr = TMR_W'(HALF_CYCLES);
                    if (q.hscl && !q.hsda)
                        d.hsda = 1'b1;
                    else if (q.hscl)
                        d.hscl = 1'b0;
                    else if (q.scl_s)
                    begin
                        d.hsda = 1'b0;
                        d.done = 1'b1;
                        d.hst  = H_IDLE;
                    end
                end
            H_LOST:
                if (stop_w)
                    d.hst = H_WAIT;
            default:
                d.hst = H_IDLE;
        endcase

        // software clear first so a same-cycle event still sets
        if (flag_clear)
        begin
            d.lost = 1'b0;
            d.coll = 1'b0;
        end
        // drop data on a lost bit; an active host drops its clock too
        if (lose_w | scoll_w)
        begin
            d.lost = 1'b1;
            d.coll = 1'b1;
            d.htx  = 1'b0;
            d.cltx = 1'b0;
            d.sdal = 1'b0;
            d.pend = 1'b0;
            d.hold = '0;
            if (hact_w)
            begin
                d.hst  = H_LOST;
                d.hscl = 1'b0;
                d.hsda = 1'b0;
            end
        end

        // Disabled port stops the host and both transmitters and lets go of the pins
        if (!en_w)
        begin
            d.hst  = H_IDLE;
            d.hscl = 1'b0;
            d.hsda = 1'b0;
            d.sdal = 1'b0;
            d.htx  = 1'b0;
            d.cltx = 1'b0;
        end
        // open drain: only ever pull low
        d.osda = en_w & (d.sdal | d.hsda);
        d.oscl = en_w & (d.hscl | d.sclh);
    end

    // State register; idle bus lines read high after reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            q       <= '0;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
            q.hst   <= H_IDLE;
        end
        else
            q <= d;
    end

    // Pin and status outputs
    assign scl_out         = 1'b0;
    assign sda_out         = 1'b0;
    assign scl_oe          = q.oscl;
    assign sda_oe          = q.osda;
    assign rx_data         = q.rxb;
    assign port_event_flag = q.evt;
    assign tx_take         = q.take;
    assign host_done       = q.done;
    assign ack_status      = q.ack;
    assign addressed       = q.addr;
    assign bus_busy        = q.busy;
    // idle needs both lines high and no busy flag
    assign bus_idle        = ~q.busy & q.scl_s & q.sda_s;
    assign arb_lost        = q.lost;
    assign bus_coll        = q.coll;

    // Checks
    sequence s_byte_done;
        rise_w && q.cnt == BIT_LAST;
    endsequence

    a_start_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start_w |=> q.busy && q.cnt == '0 && q.first)
        else $error("start did not mark bus busy");
    a_stop_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stop_w |=> !q.busy)
        else $error("stop did not free the bus");
    a_stop_low_seen: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(q.sda_s) && q.scl_s && q.scl_p && !q.lowseen |=> q.busy == $past(q.busy))
        else $error("stop taken without a clock low");
    a_pins_open_drain: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !en_w [*2] |-> !scl_oe && !sda_oe)
        else $error("pin pulled while port disabled");
    a_hold_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(q.sdal) && !q.scl_s && en_w
        |-> q.age >= (sda_hold_select ? HOLD_LONG_CYC : HOLD_SHORT_CYC))
        else $error("data changed inside hold time");
    a_clock_grab: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en_w && !clock_release_bit && !q.scl_s ##1 en_w && !clock_release_bit |=> scl_oe)
        else $error("clock not held while release bit clear");
    a_host_waits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        q.hst == H_WAIT && q.busy |=> q.hst != H_START)
        else $error("host started on busy bus");
    a_lost_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        lose_w |=> q.lost && q.coll && !q.sdal ##1 !sda_oe || q.hsda)
        else $error("data still driven after loss");
    a_lost_no_clock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (lose_w || scoll_w) && hact_w |=> q.hst == H_LOST && !q.hscl)
        else $error("host kept clock after loss");
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        q.coll && !flag_clear |=> q.coll)
        else $error("collision flag dropped without clear");
    a_rx_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_byte_done |=> port_event_flag && rx_data == $past(nb_w))
        else $error("received byte not posted");

endmodule : i2cf_core

// ---- i2cf_pkg.sv ----
// Shared constants, host states and state records for the two-wire bus framing core
package i2cf_pkg;

    // Clock rate and bus timing in their own units
    localparam int CLK_MHZ        = 100;
    localparam int HOLD_LONG_NS   = 300;
    localparam int HOLD_SHORT_NS  = 100;
    localparam int HALF_NS        = 5000;

    // Least times round up, the half period rounds down
    localparam int HOLD_LONG_CYC  = (HOLD_LONG_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_SHORT_CYC = (HOLD_SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_CYC       = (HALF_NS * CLK_MHZ / 1000 < 1) ? 1 : HALF_NS * CLK_MHZ / 1000;

    localparam int HOLD_W = 6;
    localparam int TMR_W  = 16;

    // Bit slot positions inside one nine-slot unit
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    typedef enum logic [7:0] {
        H_IDLE   = 8'h01,
        H_WAIT   = 8'h02,
        H_START  = 8'h04,
        H_SDALOW = 8'h08,
        H_LOW    = 8'h10,
        H_HIGH   = 8'h20,
        H_STOP   = 8'h40,
        H_LOST   = 8'h80
    } i2cf_host_t;

    // System-side state
    typedef struct packed {
        logic              scl_m, scl_s, scl_p;
        logic              sda_m, sda_s, sda_p;
        logic              tg_m, tg_s, tg_p;
        logic [3:0]        cnt;
        logic [7:0]        sh;
        logic [7:0]        rxb;
        logic [7:0]        txs;
        logic              first, addr, rw, cltx, htx;
        logic              ack, busy, lowseen;
        logic [HOLD_W-1:0] hold;
        logic [HOLD_W-1:0] age;
        logic              pend, sdal, sclh;
        i2cf_host_t        hst;
        logic [TMR_W-1:0]  tmr;
        logic              hscl, hsda;
        logic              evt, take, done, lost, coll;
        logic              osda, oscl;
    } i2cf_state_t;

    // Link-side state, clocked by the bus clock line
    typedef struct packed {
        logic r1, r2;
        logic bitv;
        logic tog;
    } i2cf_link_t;

endpackage : i2cf_pkg

// ---- i2cf_bus_model.sv ----
// Behavioural far-side party on the two-wire bus, in host and client roles
`timescale 1ns/1ps
module i2cf_bus_model #(
    parameter int T = 400 // Half bit time in ns
) (
    input  wire logic scl_w,  // Resolved clock line
    input  wire logic sda_w,  // Resolved data line
    output logic      scl_lo, // Pull clock line low
    output logic      sda_lo  // Pull data line low
);
    // Both lines released; pull-ups make them high
    initial
    begin
        scl_lo = 1'b0;
        sda_lo = 1'b0;
    end

    task automatic pull_scl(input logic v);
        scl_lo = v;
    endtask : pull_scl

    task automatic pull_sda(input logic v);
        sda_lo = v;
    endtask : pull_sda

    // Link clock pulses at 30 ns period with data high, used during reset
    task automatic kick();
        repeat (4)
        begin
            scl_lo = 1'b1;
            #15;
            scl_lo = 1'b0;
            #15;
        end
    endtask : kick

    task automatic start();
        sda_lo = 1'b1;
        #(T);
        scl_lo = 1'b1;
    endtask : start

    // Data set while clock low, sampled at the rise; waits out stretching
    task automatic slot(input logic b, output logic r);
        sda_lo = !b;
        #(T);
        scl_lo = 1'b0;
        wait (scl_w === 1'b1);
        r = sda_w;
        #(T);
        scl_lo = 1'b1;
    endtask : slot

    // Eight bits MSB first, then the ninth slot
    task automatic xfer(input logic [7:0] tx, input logic ain, output logic [7:0] rx, output logic aout);
        for (int i = 7; i >= 0; i--)
            slot(tx[i], rx[i]);
        slot(ain, aout);
    endtask : xfer

    // Host role closes a frame after a clock low period
    task automatic stop();
        sda_lo = 1'b1;
        #(T);
        scl_lo = 1'b0;
        #(T);
        sda_lo = 1'b0;
        #(T);
    endtask : stop

    // Client role: gather a byte at rises, pull the ninth slot low
    task automatic serve(output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge scl_w);
            rx[i] = sda_w;
        end
        @(negedge scl_w);
        #50;
        sda_lo = 1'b1;
        @(negedge scl_w);
        #50;
        sda_lo = 1'b0;
    endtask : serve
endmodule : i2cf_bus_model

// ---- testbench.sv ----
// Self-checking bench for the two-wire bus framing core
`timescale 1ns/1ps
module testbench;
    import i2cf_pkg::*;
    localparam int HALF = 40;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       port_enable_bit = 1'b1;
    logic       clock_release_bit = 1'b1;
    logic       sda_hold_select = 1'b0;
    logic       start_irq_enable = 1'b0;
    logic       stop_irq_enable = 1'b0;
    logic       ss_irq_mode = 1'b0;
    logic       host_go = 1'b0;
    logic       flag_clear = 1'b0;
    logic       i2c_mode_sel = 1'b1;
    logic [7:0] own_address_reg = 8'h5a;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data, rx;
    logic       scl_oe, sda_oe, scl_lo, sda_lo, scl_w, sda_w, a;
    logic       scl_dv, sda_dv, tx_take;
    logic       port_event_flag, host_done, ack_status, addressed, bus_busy, bus_idle, arb_lost, bus_coll;
    int         n_fail = 0;
    int         compares = 0;
    int         n_evt = 0;
    int         n_take = 0;
    int         e0;

    always #5 ref_clk = ~ref_clk;
    // One wire per line carries both the input and the output of each function
    // Open-drain wires: low if any party pulls
    assign scl_w = !(scl_lo | (scl_oe & !scl_dv));
    assign sda_w = !(sda_lo | (sda_oe & !sda_dv));
    always @(posedge ref_clk) if (port_event_flag === 1'b1) n_evt <= n_evt + 1;
    always @(posedge ref_clk) if (tx_take === 1'b1) n_take <= n_take + 1;

    i2cf_core #(.HALF_CYCLES(HALF)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_w), .scl_out(scl_dv),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_dv), .sda_oe(sda_oe), .port_enable_bit(port_enable_bit),
        .i2c_mode_sel(i2c_mode_sel), .clock_release_bit(clock_release_bit), .sda_hold_select(sda_hold_select),
        .start_irq_enable(start_irq_enable), .stop_irq_enable(stop_irq_enable), .ss_irq_mode(ss_irq_mode),
        .own_address_reg(own_address_reg), .host_go(host_go), .tx_data(tx_data), .flag_clear(flag_clear),
        .rx_data(rx_data), .port_event_flag(port_event_flag), .tx_take(tx_take), .host_done(host_done),
        .ack_status(ack_status), .addressed(addressed), .bus_busy(bus_busy), .bus_idle(bus_idle),
        .arb_lost(arb_lost), .bus_coll(bus_coll));
    i2cf_bus_model #(.T(HALF * 10)) bm (.scl_w(scl_w), .sda_w(sda_w), .scl_lo(scl_lo), .sda_lo(sda_lo));

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic pulse_go();
        tick(1);
        host_go = 1'b1;
        tick(1);
        host_go = 1'b0;
    endtask : pulse_go

    // Bounded wait for the host completion pulse
    task automatic wait_done();
        int k;
        k = 0;
        while (host_done !== 1'b1 && k < 5000)
        begin
            tick(1);
            k++;
        end
        chk(8'(host_done), 8'h01, "host done");
    endtask : wait_done

    task automatic end_sim();
        $display("TB: compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        #400000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        // Link side needs clock edges while reset is low
        fork
            bm.kick();
            tick(10);
        join
        rst_n = 1'b1;
        tick(2);
        chk({bus_idle, bus_busy, sda_oe, scl_oe, arb_lost, bus_coll, host_done, 1'b0}, 8'h80, "reset state");
        $display("TB: test reset done");
        // Empty frames with each event enable set alone, then with none set
        for (int k = 0; k < 4; k++)
        begin
            {start_irq_enable, stop_irq_enable, ss_irq_mode} = 3'b100 >> k;
            e0 = n_evt;
            bm.start();
            bm.slot(1'b1, a);
            bm.stop();
            tick(10);
            chk(8'(n_evt - e0), 8'(int'(start_irq_enable | ss_irq_mode) + int'(stop_irq_enable | ss_irq_mode)),
                "start stop events");
        end
        $display("TB: test events done");
        start_irq_enable = 1'b1;
        stop_irq_enable = 1'b1;
        e0 = n_evt;
        bm.pull_sda(1'b1);
        tick(10);
        bm.pull_sda(1'b0);
        tick(10);
        chk(8'(n_evt - e0), 8'h01, "start only");
        chk({6'h0, bus_busy, bus_idle}, 8'h02, "bus active");
        e0 = n_evt;
        bm.start();
        bm.xfer(8'h5a, 1'b1, rx, a);
        chk(8'(a), 8'h00, "address ack");
        chk(rx_data, 8'h5a, "address byte");
        bm.xfer(8'hc3, 1'b1, rx, a);
        chk(8'(a), 8'h00, "data ack");
        chk(rx_data, 8'hc3, "data byte");
        chk({6'h0, ack_status, addressed}, 8'h03, "ack and match");
        bm.stop();
        tick(10);
        chk(8'(n_evt - e0), 8'h04, "frame events");
        chk(8'(bus_idle), 8'h01, "idle again");
        $display("TB: test client write done");
        sda_hold_select = 1'b1;
        tx_data = 8'ha5;
        e0 = n_take;
        bm.start();
        bm.xfer(8'h5b, 1'b1, rx, a);
        chk(8'(a), 8'h00, "read address ack");
        bm.xfer(8'hff, 1'b0, rx, a);
        chk(rx, 8'ha5, "read byte one");
        bm.xfer(8'hff, 1'b1, rx, a);
        chk(rx, 8'ha5, "read byte two");
        bm.stop();
        chk(8'(n_take - e0), 8'h02, "bytes loaded");
        own_address_reg = 8'h24;
        bm.start();
        bm.xfer(8'h5a, 1'b1, rx, a);
        chk({6'h0, a, addressed}, 8'h02, "no match");
        bm.stop();
        $display("TB: test client read done");
        bm.start();
        tick(1);
        clock_release_bit = 1'b0;
        bm.pull_scl(1'b1);
        tick(10);
        chk(8'(scl_oe), 8'h01, "clock grabbed");
        bm.pull_scl(1'b0);
        tick(10);
        chk(8'(scl_w), 8'h00, "clock held");
        clock_release_bit = 1'b1;
        tick(5);
        chk(8'(scl_w), 8'h01, "clock released");
        bm.pull_scl(1'b1);
        bm.stop();
        $display("TB: test stretch done");
        tx_data = 8'h96;
        bm.start();
        pulse_go();
        tick(100);
        chk({6'h0, sda_oe, scl_oe}, 8'h00, "waits for idle");
        bm.slot(1'b1, a);
        bm.stop();
        fork
            bm.serve(rx);
            wait_done();
        join
        chk(rx, 8'h96, "host byte");
        chk(8'(ack_status), 8'h01, "host ack");
        $display("TB: test host done");
        tx_data = 8'hff;
        pulse_go();
        @(negedge scl_w);
        #50;
        bm.pull_sda(1'b1);
        for (int k = 0; k < 2000 && arb_lost !== 1'b1; k++)
            tick(1);
        tick(3);
        chk({4'h0, arb_lost, bus_coll, sda_oe, scl_oe}, 8'h0c, "lost arbitration");
        tick(1);
        flag_clear = 1'b1;
        tick(1);
        flag_clear = 1'b0;
        tick(2);
        chk({6'h0, arb_lost, bus_coll}, 8'h00, "flags cleared");
        fork
            bm.serve(rx);
            begin
                bm.pull_sda(1'b0);
                wait_done();
            end
        join
        chk(rx, 8'hff, "retry byte");
        $display("TB: test arbitration done");
        pulse_go();
        tick(20);
        bm.pull_sda(1'b1);
        tick(10);
        chk({6'h0, arb_lost, bus_coll}, 8'h03, "start collision");
        bm.pull_scl(1'b1);
        tick(10);
        bm.pull_scl(1'b0);
        tick(10);
        bm.pull_sda(1'b0);
        wait_done();
        chk(8'(ack_status), 8'h00, "no ack");
        $display("TB: test start collision done");
        port_enable_bit = 1'b0;
        clock_release_bit = 1'b0;
        bm.pull_scl(1'b1);
        tick(10);
        chk({4'h0, scl_dv, sda_dv, scl_oe, sda_oe}, 8'h00, "port off");
        port_enable_bit = 1'b1;
        i2c_mode_sel = 1'b0;
        tick(10);
        chk({6'h0, scl_oe, sda_oe}, 8'h00, "mode off");
        bm.pull_scl(1'b0);
        $display("TB: test port enable done");
        end_sim();
    end
endmodule : testbench
